// *** design/cycle_cost.sv ***
`timescale 1ns/1ps
`include "decode_defines.svh"
module cycle_cost
   import decode_pkg::*;
(
   // class and outcome
   input  wire instr_class_t cls,
   input  wire exec_cond_t   cond,
   // cost in instruction cycles
   output logic [4:0]        cycles
);

   always_comb
   begin
      unique case (cls)
         CLS_BR_COND:
            cycles = cond.cond_true ? `CYC_TWO : `CYC_ONE; // RQ4
         CLS_BR_UNCOND, CLS_TABLE:
            cycles = `CYC_TWO; // RQ5
         CLS_RETURN:
            cycles = `CYC_RETURN; // RQ5
         CLS_SKIP:
            // skipping a two-word instruction flushes both its words
            cycles = !cond.skip_taken ? `CYC_ONE :
                     (cond.skip_over_two_word ? `CYC_THREE : `CYC_TWO); // RQ6
         CLS_TWO_WORD, CLS_MOVD:
            cycles = `CYC_TWO; // RQ7
         CLS_DIV:
            cycles = `CYC_DIV;
         default:
            cycles = (cond.cond_true || cond.pc_change) ?
                     `CYC_TWO : `CYC_ONE; // RQ4
      endcase
   end

endmodule : cycle_cost

// *** design/field_extract.sv ***
`timescale 1ns/1ps
`include "decode_defines.svh"
module field_extract
   import decode_pkg::*;
(
   // raw word
   input  wire logic [23:0] word,
   // decoded fields
   output decoded_t         dec
);

   logic [3:0] grp;

   always_comb
   begin
      grp = word[`OPC_LO+`GRP_HI:`OPC_LO+`GRP_LO];
      dec = '0;
      dec.opcode = word[`OPC_HI:`OPC_LO];
      dec.size   = size_sel_t'(word[`OPC_LO+`SIZE_HI:`OPC_LO+`SIZE_LO]); // RQ16
      unique case (grp)
         `GRP_NOP:       dec.cls = CLS_NOP;
         `GRP_WREG3:     dec.cls = CLS_WREG3;
         `GRP_FILE:      dec.cls = CLS_FILE;
         `GRP_BIT_LIT:   dec.cls = CLS_BIT_LIT;
         `GRP_BIT_IND:   dec.cls = CLS_BIT_IND;
         `GRP_TEN_BIT_LITERAL:     dec.cls = CLS_TEN_BIT_LITERAL;
         `GRP_LIT5:      dec.cls = CLS_LIT5;
         `GRP_DIV:       dec.cls = CLS_DIV;
         `GRP_BR_COND:   dec.cls = CLS_BR_COND;
         `GRP_BR_UNCOND: dec.cls = CLS_BR_UNCOND;
         `GRP_SKIP:      dec.cls = CLS_SKIP;
         `GRP_TWO_WORD:  dec.cls = CLS_TWO_WORD;
         `GRP_TABLE:     dec.cls = CLS_TABLE;
         `GRP_RETURN:    dec.cls = CLS_RETURN;
         `GRP_MOVD:      dec.cls = CLS_MOVD;
         default:        dec.cls = CLS_MISC;
      endcase
      // base never carries a modifier
      dec.base_src_reg   = word[`BASE_HI:`BASE_LO]; // RQ8 RQ14
      dec.second_src_reg = word[`SRC_HI:`SRC_LO];
      dec.src_mode       = word[`SMODE_HI:`SMODE_LO];
      dec.dest_reg       = word[`DEST_HI:`DEST_LO];
      dec.dest_mode      = word[`DMODE_HI:`DMODE_LO];
      dec.dest_present   = 1'b1;
      unique case (dec.cls)
         CLS_FILE:
         begin
            dec.file_addr     = word[`FILE_HI:`FILE_LO]; // RQ9
            // bit set sends the result back to memory
            dec.dest_is_accum = !word[`FILE_DEST_BIT];
            dec.dest_reg      = `ACCUMULATOR_REG_ZERO; // RQ14
            dec.dest_mode     = 2'h0;
            dec.dest_present  = word[`FILE_DEST_BIT];
         end
         CLS_BIT_LIT, CLS_BIT_IND:
         begin
            dec.bit_number_field = word[`BASE_HI:`BASE_LO]; // RQ12
            dec.bit_indirect     = (dec.cls == CLS_BIT_IND); // RQ10
            dec.dest_present     = 1'b0;
         end
         CLS_TEN_BIT_LITERAL:
         begin
            // result returns to the source: no separate destination
            dec.ten_bit_literal = word[`TEN_BIT_LITERAL_HI:`TEN_BIT_LITERAL_LO];
            dec.base_src_reg    = word[`SRC_HI:`SRC_LO];
            dec.dest_reg        = word[`SRC_HI:`SRC_LO]; // RQ11
            dec.dest_mode       = 2'h0;
            dec.dest_present    = 1'b0;
            dec.lit_range_err   = (dec.size == SIZE_BYTE) &&
                                  (dec.ten_bit_literal > `BYTE_LIT_MAX); // RQ13
         end
         CLS_LIT5:
         begin
            dec.lit5     = word[`LIT5_HI:`LIT5_LO]; // RQ11
            dec.src_mode = 2'h0;
         end
         CLS_DIV:
         begin
            dec.dividend_divisor_pair = word[`DIVIDEND_HI:`SRC_LO];
            dec.src_mode     = 2'h0; // RQ17
            dec.dest_mode    = 2'h0;
            dec.dest_present = 1'b0;
         end
         default:
         begin
            dec.dest_present = (dec.cls == CLS_WREG3) ||
                               (dec.cls == CLS_MOVD) ||
                               (dec.cls == CLS_MISC);
         end
      endcase
   end

endmodule : field_extract

// *** design/instr_decoder.sv ***
// Summary of operation
// RQ1: one word each; three opcodes take two
// RQ2: eight-bit opcode, rest are operand fields
// RQ3: second word upper byte zero; alone acts NOP
// RQ4: one cycle; two when test passes
// RQ5: branches, tables, returns take two/three cycles
// RQ6: taken skip costs two or three cycles
// RQ7: double moves and two-word ops take two
// RQ8: three operands: base, source, destination
// RQ9: file ops: address plus memory or accumulator
// RQ10: bit number immediate or from base register
// RQ11: literal ops: destination only when different
// RQ12: bit number field is four bits
// RQ13: ten-bit literal max 255 in byte mode
// RQ14: sixteen registers; register zero is accumulator
// RQ15: keep carry, digit carry, negative, overflow, zero
// RQ16: size suffix selects byte/double/shadow/word
// RQ17: divide uses directly addressed register pair
// RQ18: every instruction reports its cycle count
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "decode_defines.svh"
module instr_decoder
   import decode_pkg::*;
(
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         reset_n,
   // apb slave
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic              pready,
   output logic [31:0]       prdata,
   output logic              pslverr,
   // fetch side
   input  wire logic         instr_valid,
   input  wire logic [23:0]  instr_word,
   output logic              instr_ready,
   // execute side
   input  wire exec_cond_t   exec_cond,
   input  wire flag_update_t flag_upd,
   output logic              dec_valid,
   output decoded_t          dec_out,
   output logic [4:0]        dec_cycles,
   output logic              second_valid,
   output logic [15:0]       second_operand,
   output logic              nop_insert,
   output logic [4:0]        status_flags
);

   typedef enum logic [1:0] {ST_FIRST, ST_SECOND, ST_STALL} dec_state_t;

   dec_state_t state_reg, state_next;
   decoded_t   dec_reg, dec_next, dec_comb;
   logic [4:0] cyc_reg, cyc_next, cyc_comb;
   logic [4:0] stall_reg, stall_next;
   logic       dvalid_reg, dvalid_next;
   logic       svalid_reg, svalid_next;
   logic [15:0] sop_reg, sop_next;
   logic [1:0] ctrl_reg, ctrl_next;
   logic [4:0] flags_reg, flags_next;
   logic       secerr_reg, secerr_next;
   logic       literr_reg, literr_next;
   logic [31:0] count_reg, count_next;
   logic [31:0] rdata_reg, rdata_next;
   logic       err_reg, err_next;
   logic       take;
   logic       bus_wr;
   logic       bus_rd;
   logic       bad_second;
   logic       addr_ok;

   field_extract u_extract
   (
      .word (instr_word),
      .dec  (dec_comb)
   );

   cycle_cost u_cost
   (
      .cls    (dec_comb.cls),
      .cond   (exec_cond),
      .cycles (cyc_comb)
   );

   // fetch is held off while filler cycles are issued
   assign instr_ready = ctrl_reg[`CTRL_EN_BIT] && (state_reg != ST_STALL);
   assign take        = instr_valid && instr_ready;
   assign bad_second  = (instr_word[`OPC_HI:`OPC_LO] != 8'h00); // RQ3

   // decode sequencing
   always_comb
   begin
      state_next  = state_reg;
      dec_next    = dec_reg;
      cyc_next    = cyc_reg;
      stall_next  = stall_reg;
      dvalid_next = 1'b0;
      svalid_next = 1'b0;
      sop_next    = sop_reg;
      secerr_next = secerr_reg;
      literr_next = literr_reg;
      count_next  = count_reg;
      unique case (state_reg)
         ST_FIRST:
         begin
            if (take)
            begin
               dec_next    = dec_comb; // RQ2
               cyc_next    = cyc_comb; // RQ18
               dvalid_next = 1'b1;
               count_next  = count_reg + 32'h0000_0001;
               if (dec_comb.lit_range_err)
                  literr_next = 1'b1; // RQ13
               if (dec_comb.cls == CLS_TWO_WORD)
                  // second cycle is spent fetching the second word
                  state_next = ST_SECOND; // RQ1 RQ7
               else if (cyc_comb > `CYC_ONE)
               begin
                  stall_next = cyc_comb - `CYC_ONE; // RQ4 RQ5 RQ6
                  state_next = ST_STALL;
               end
            end
         end
         ST_SECOND:
         begin
            if (take)
            begin
               svalid_next = 1'b1;
               sop_next    = instr_word[15:0];
               state_next  = ST_FIRST;
               if (bad_second)
                  secerr_next = 1'b1; // RQ3
            end
         end
         ST_STALL:
         begin
            stall_next = stall_reg - `CYC_ONE;
            if (stall_reg == `CYC_ONE)
               state_next = ST_FIRST;
         end
      endcase
      // software clears by writing one; a new error wins
      if (bus_wr && (paddr == `OFF_STATUS))
      begin
         if (pwdata[`ST_SECERR_BIT] && !(svalid_next && bad_second))
            secerr_next = 1'b0;
         if (pwdata[`ST_LITERR_BIT] && !(dvalid_next &&
                                         dec_comb.lit_range_err))
            literr_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg  <= ST_FIRST;
         dec_reg    <= '0;
         cyc_reg    <= 5'h00;
         stall_reg  <= 5'h00;
         dvalid_reg <= 1'b0;
         svalid_reg <= 1'b0;
         sop_reg    <= 16'h0000;
         secerr_reg <= 1'b0;
         literr_reg <= 1'b0;
         count_reg  <= 32'h0000_0000;
      end
      else
      begin
         state_reg  <= state_next;
         dec_reg    <= dec_next;
         cyc_reg    <= cyc_next;
         stall_reg  <= stall_next;
         dvalid_reg <= dvalid_next;
         svalid_reg <= svalid_next;
         sop_reg    <= sop_next;
         secerr_reg <= secerr_next;
         literr_reg <= literr_next;
         count_reg  <= count_next;
      end
   end

   assign dec_valid      = dvalid_reg;
   assign dec_out        = dec_reg;
   assign dec_cycles     = cyc_reg;
   assign second_valid   = svalid_reg;
   assign second_operand = sop_reg;
   assign nop_insert     = (state_reg == ST_STALL); // RQ4

   // status flags: execute updates win over a software write
   always_comb
   begin
      flags_next = flags_reg;
      if (bus_wr && (paddr == `OFF_FLAGS))
         flags_next = pwdata[4:0];
      for (int i = 0; i < 5; i++)
      begin
         if (flag_upd.we[i])
            flags_next[i] = flag_upd.val[i]; // RQ15
      end
      // a sticky-zero result can only clear zero, never set it
      if (flag_upd.we[`FLAG_Z] && flag_upd.sticky_zero)
         flags_next[`FLAG_Z] = flags_reg[`FLAG_Z] &&
                               flag_upd.val[`FLAG_Z]; // RQ15
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         flags_reg <= `FLAGS_RESET;
      else
         flags_reg <= flags_next;
   end

   assign status_flags = flags_reg;

   // apb: zero wait states, error on unmapped offsets
   assign bus_wr  = psel && penable && pwrite && addr_ok;
   assign bus_rd  = psel && !penable && !pwrite;
   assign addr_ok = (paddr == `OFF_CTRL) || (paddr == `OFF_STATUS) ||
                    (paddr == `OFF_FLAGS) || (paddr == `OFF_COUNT);
   assign pready  = 1'b1;

   always_comb
   begin
      ctrl_next  = ctrl_reg;
      rdata_next = rdata_reg;
      err_next   = err_reg;
      if (bus_wr && (paddr == `OFF_CTRL))
         ctrl_next = pwdata[1:0];
      if (psel && !penable)
      begin
         err_next   = !addr_ok;
         rdata_next = 32'h0000_0000;
         if (bus_rd)
         begin
            unique case (paddr)
               `OFF_CTRL:   rdata_next = {30'h0, ctrl_reg};
               `OFF_STATUS: rdata_next = {20'h0, literr_reg, secerr_reg,
                                          (state_reg == ST_SECOND),
                                          cyc_reg, dec_reg.cls};
               `OFF_FLAGS:  rdata_next = {27'h0, flags_reg};
               `OFF_COUNT:  rdata_next = count_reg;
               default:     rdata_next = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_reg  <= `CTRL_RESET;
         rdata_reg <= 32'h0000_0000;
         err_reg   <= 1'b0;
      end
      else
      begin
         ctrl_reg  <= ctrl_next;
         rdata_reg <= rdata_next;
         err_reg   <= err_next;
      end
   end

   assign prdata  = rdata_reg;
   assign pslverr = psel && penable && err_reg;

endmodule : instr_decoder

// *** pkg/decode_defines.svh ***
`ifndef DECODE_DEFINES_SVH
`define DECODE_DEFINES_SVH

// instruction word layout
`define INSTR_W          24
`define OPC_HI           23
`define OPC_LO           16
`define GRP_HI           7
`define GRP_LO           4
`define SIZE_HI          1
`define SIZE_LO          0
`define BASE_HI          15
`define BASE_LO          12
`define DMODE_HI         11
`define DMODE_LO         10
`define DEST_HI          9
`define DEST_LO          6
`define SMODE_HI         5
`define SMODE_LO         4
`define SRC_HI           3
`define SRC_LO           0
`define FILE_DEST_BIT    15
`define FILE_HI          12
`define FILE_LO          0
`define BIT_IND_BIT      11
`define TEN_BIT_LITERAL_HI         13
`define TEN_BIT_LITERAL_LO         4
`define LIT5_HI          4
`define LIT5_LO          0
`define DIVIDEND_HI      7
`define DIVIDEND_LO      4

// opcode groups (upper nibble of the opcode)
`define GRP_NOP          4'h0
`define GRP_WREG3        4'h1
`define GRP_FILE         4'h2
`define GRP_BIT_LIT      4'h3
`define GRP_BIT_IND      4'h4
`define GRP_TEN_BIT_LITERAL        4'h5
`define GRP_LIT5         4'h6
`define GRP_DIV          4'h7
`define GRP_BR_COND      4'h8
`define GRP_BR_UNCOND    4'h9
`define GRP_SKIP         4'ha
`define GRP_TWO_WORD     4'hb
`define GRP_TABLE        4'hc
`define GRP_RETURN       4'hd
`define GRP_MOVD         4'he

// size suffix codes
`define SZ_WORD          2'h0
`define SZ_BYTE          2'h1
`define SZ_DOUBLE        2'h2
`define SZ_SHADOW        2'h3

`define ACCUMULATOR_REG_ZERO 4'h0
`define BYTE_LIT_MAX     10'h0ff

// cycle costs
`define CYC_W            5
`define CYC_ONE          5'h01
`define CYC_TWO          5'h02
`define CYC_THREE        5'h03
`define CYC_DIV          5'h12
`define CYC_RETURN       5'h03

// register map
`define OFF_CTRL         8'h00
`define OFF_STATUS       8'h04
`define OFF_FLAGS        8'h08
`define OFF_COUNT        8'h0c
`define CTRL_RESET       2'h1
`define FLAGS_RESET      5'h00
`define CTRL_EN_BIT      0
`define CTRL_STRICT_BIT  1
`define ST_SECERR_BIT    10
`define ST_LITERR_BIT    11
`define FLAG_C           0
`define FLAG_DC          1
`define FLAG_N           2
`define FLAG_OV          3
`define FLAG_Z           4

`endif

// *** pkg/decode_pkg.sv ***
package decode_pkg;

   typedef enum logic [3:0] {
      CLS_NOP, CLS_WREG3, CLS_FILE, CLS_BIT_LIT, CLS_BIT_IND, CLS_TEN_BIT_LITERAL,
      CLS_LIT5, CLS_DIV, CLS_BR_COND, CLS_BR_UNCOND, CLS_SKIP,
      CLS_TWO_WORD, CLS_TABLE, CLS_RETURN, CLS_MOVD, CLS_MISC
   } instr_class_t;

   typedef enum logic [1:0] {
      SIZE_WORD, SIZE_BYTE, SIZE_DOUBLE, SIZE_SHADOW
   } size_sel_t;

   typedef struct packed {
      instr_class_t cls;
      size_sel_t    size;
      logic [7:0]   opcode;
      logic [3:0]   base_src_reg;
      logic [1:0]   src_mode;
      logic [3:0]   second_src_reg;
      logic [1:0]   dest_mode;
      logic [3:0]   dest_reg;
      logic         dest_present;
      logic [12:0]  file_addr;
      logic         dest_is_accum;
      logic [3:0]   bit_number_field;
      logic         bit_indirect;
      logic [9:0]   ten_bit_literal;
      logic [4:0]   lit5;
      logic         lit_range_err;
      logic [7:0]   dividend_divisor_pair;
   } decoded_t;

   typedef struct packed {
      logic cond_true;
      logic pc_change;
      logic skip_taken;
      logic skip_over_two_word;
   } exec_cond_t;

   typedef struct packed {
      logic [4:0] we;
      logic [4:0] val;
      logic       sticky_zero;
   } flag_update_t;

endpackage : decode_pkg

// *** tb/decode_checker.sv ***
`timescale 1ns/1ps
module decode_checker
   import decode_pkg::*;
(
   // clock and reset
   input wire logic         core_clk,
   input wire logic         reset_n,
   // fetch side
   input wire logic         instr_valid,
   input wire logic [23:0]  instr_word,
   input wire logic         instr_ready,
   // execute side
   input wire exec_cond_t   exec_cond,
   input wire flag_update_t flag_upd,
   input wire logic         dec_valid,
   input wire decoded_t     dec_out,
   input wire logic [4:0]   dec_cycles,
   input wire logic         second_valid,
   input wire logic [15:0]  second_operand,
   input wire logic         nop_insert,
   input wire logic [4:0]   status_flags
);
   logic       take;
   logic       first;
   logic [3:0] grp;
   logic       pend_reg;
   logic       pend_next;
   assign take  = instr_valid && instr_ready;
   assign first = take && !pend_reg;
   assign grp   = instr_word[23:20];
   // tracks whether the next take is a second word
   always_comb
   begin
      pend_next = pend_reg;
      if (take)
         pend_next = !pend_reg && (grp == 4'hb);
   end
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         pend_reg <= 1'b0;
      else
         pend_reg <= pend_next;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_cost_two;
      dec_valid && dec_cycles == 5'h02;
   endsequence
   sequence s_fill_one;
      nop_insert && !instr_ready ##1 !nop_insert;
   endsequence
   a_branch_fill: assert property (
      first && grp == 4'h9 |=> s_cost_two ##0 s_fill_one)
      else $error("branch cost or filler wrong");
   a_opcode_pulse: assert property (
      first |=> dec_valid && !second_valid
      && dec_out.opcode == $past(instr_word[23:16]))
      else $error("first word not decoded");
   a_second_word: assert property (
      take && pend_reg |=> second_valid && !dec_valid
      && second_operand == $past(instr_word[15:0]))
      else $error("second word not passed");
   a_return_cost: assert property (
      first && grp == 4'hd |=> dec_cycles == 5'h03)
      else $error("return cost wrong");
   a_div_direct: assert property (
      first && grp == 4'h7 |=> dec_cycles == 5'h12
      && dec_out.dest_mode == 2'h0 && dec_out.src_mode == 2'h0)
      else $error("divide decode wrong");
   a_skip_cost: assert property (
      first && grp == 4'ha && exec_cond.skip_taken |=> dec_cycles ==
      ($past(exec_cond.skip_over_two_word) ? 5'h03 : 5'h02))
      else $error("skip cost wrong");
   a_cond_cost: assert property (
      first && grp == 4'h8 |=> dec_cycles ==
      ($past(exec_cond.cond_true) ? 5'h02 : 5'h01))
      else $error("conditional cost wrong");
   a_size_field: assert property (
      first |=> dec_out.size == $past(instr_word[17:16]))
      else $error("size suffix wrong");
   a_file_accum: assert property (
      dec_valid && dec_out.cls == CLS_FILE |-> dec_out.dest_reg == 4'h0)
      else $error("file destination wrong");
   a_bit_number: assert property (
      first && grp == 4'h3 |=>
      dec_out.bit_number_field == $past(instr_word[15:12]))
      else $error("bit number wrong");
   a_lit_range: assert property (
      first && grp == 4'h5 && instr_word[17:16] == 2'h1 |=>
      dec_out.lit_range_err == ($past(instr_word[13:4]) > 10'h0ff))
      else $error("literal range flag wrong");
   a_sticky_zero: assert property (
      flag_upd.we[4] && flag_upd.sticky_zero |=> status_flags[4] ==
      ($past(status_flags[4]) & $past(flag_upd.val[4])))
      else $error("zero flag not sticky");
endmodule : decode_checker
bind instr_decoder decode_checker chk_u (.core_clk, .reset_n,
   .instr_valid, .instr_word, .instr_ready, .exec_cond, .flag_upd,
   .dec_valid, .dec_out, .dec_cycles, .second_valid, .second_operand,
   .nop_insert, .status_flags);

// *** tb/mcu_instruction_decode_timing_tb.sv ***
`timescale 1ns/1ps
module mcu_instruction_decode_timing_tb
   import decode_pkg::*;
;
   logic         core_clk;
   logic         reset_n;
   logic         psel;
   logic         penable;
   logic         pwrite;
   logic [7:0]   paddr;
   logic [31:0]  pwdata;
   logic         pready;
   logic [31:0]  prdata;
   logic         pslverr;
   logic         instr_valid;
   logic [23:0]  instr_word;
   logic         instr_ready;
   exec_cond_t   exec_cond;
   flag_update_t flag_upd;
   logic         dec_valid;
   decoded_t     dec_out;
   logic [4:0]   dec_cycles;
   logic         second_valid;
   logic [15:0]  second_operand;
   logic         nop_insert;
   logic [4:0]   status_flags;
   logic [31:0]  rd;
   logic         err;
   int           bad_count;
   int           n_tests;
   instr_decoder dut_u (.core_clk, .reset_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .prdata, .pslverr, .instr_valid,
      .instr_word, .instr_ready, .exec_cond, .flag_upd, .dec_valid,
      .dec_out, .dec_cycles, .second_valid, .second_operand,
      .nop_insert, .status_flags);
   prog_mem pm_u (.core_clk, .reset_n, .instr_ready, .instr_valid,
      .instr_word, .exec_cond);
   initial core_clk = 1'b0;
   always #10 core_clk = ~core_clk;
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   task automatic stuck();
      bad_count++;
      $display("mismatch at %0t: handshake timeout", $time);
      conclude();
   endtask : stuck
   task automatic check(input logic ok, input string what);
      n_tests++;
      if (ok !== 1'b1)
      begin
         bad_count++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge core_clk);
      end
      if (n == 20)
         stuck();
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // one single-word instruction, then its cost and class
   task automatic issue(input logic [23:0] w, input exec_cond_t c,
                        input logic [4:0] cyc);
      @(posedge core_clk);
      pm_u.offer(w, c, 1'b1);
      #1;
      check(dec_valid === 1'b1 && dec_cycles === cyc, "cost");
      check(dec_out.cls === instr_class_t'(w[23:20]), "class");
   endtask : issue
   initial
   begin
      bad_count = 0;
      n_tests = 0;
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      flag_upd = '0;
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      #1;
      check(instr_ready === 1'b1 && status_flags === 5'h00, "reset");
      apb(1'b0, 8'h00, 32'h0);
      check(rd === 32'h1, "control reset value");
      apb(1'b0, 8'h10, 32'h0);
      check(err === 1'b1 && rd === 32'h0, "unmapped read");
      $display("test reset done");
      issue(24'h000000, 4'h0, 5'h01);
      issue(24'h110000, 4'h0, 5'h01);
      issue(24'h110000, 4'h8, 5'h02);
      issue(24'h200000, 4'h4, 5'h02);
      issue(24'h800000, 4'h0, 5'h01);
      issue(24'h800000, 4'h8, 5'h02);
      issue(24'h900000, 4'h0, 5'h02);
      issue(24'hc00000, 4'h0, 5'h02);
      issue(24'hd00000, 4'h0, 5'h03);
      issue(24'ha00000, 4'h0, 5'h01);
      issue(24'ha00000, 4'h2, 5'h02);
      issue(24'ha00000, 4'h3, 5'h03);
      issue(24'he00000, 4'h0, 5'h02);
      issue(24'h7000a9, 4'h0, 5'h12);
      check(dec_out.dividend_divisor_pair === 8'ha9, "div pair");
      $display("test cycle costs done");
      for (int s = 0; s < 4; s++)
      begin
         issue({6'h04, 2'(s), 16'h0}, 4'h0, 5'h01);
         check(dec_out.size === size_sel_t'(s), "size");
      end
      issue(24'h11abcd, 4'h0, 5'h01);
      check(dec_out.base_src_reg === 4'ha && dec_out.dest_mode === 2'h2
         && dec_out.dest_reg === 4'hf && dec_out.src_mode === 2'h0
         && dec_out.second_src_reg === 4'hd, "three operands");
      issue(24'h200123, 4'h0, 5'h01);
      check(dec_out.dest_is_accum === 1'b1
         && dec_out.file_addr === 13'h0123, "file operands");
      issue(24'h30f000, 4'h0, 5'h01);
      check(dec_out.bit_number_field === 4'hf
         && dec_out.bit_indirect === 1'b0, "bit literal");
      issue(24'h405000, 4'h0, 5'h01);
      check(dec_out.bit_indirect === 1'b1
         && dec_out.base_src_reg === 4'h5, "bit indirect");
      issue(24'h513ff3, 4'h0, 5'h01);
      check(dec_out.lit_range_err === 1'b1
         && dec_out.dest_present === 1'b0, "byte literal");
      issue(24'h503ff3, 4'h0, 5'h01);
      check(dec_out.lit_range_err === 1'b0
         && dec_out.ten_bit_literal === 10'h3ff, "word literal");
      issue(24'h60003f, 4'h0, 5'h01);
      check(dec_out.lit5 === 5'h1f && dec_out.src_mode === 2'h0, "lit5");
      $display("test operand fields done");
      @(posedge core_clk);
      pm_u.offer(24'hb00000, 4'h0, 1'b0);
      pm_u.offer(24'h00beef, 4'h0, 1'b1);
      #1;
      check(second_valid === 1'b1 && second_operand === 16'hbeef
         && dec_cycles === 5'h02, "two words");
      @(posedge core_clk);
      pm_u.offer(24'hb00000, 4'h0, 1'b0);
      pm_u.offer(24'h120000, 4'h0, 1'b1);
      apb(1'b0, 8'h04, 32'h0);
      check(rd[11:0] === 12'hc2b, "sticky errors");
      apb(1'b1, 8'h04, 32'h00000c00);
      apb(1'b0, 8'h04, 32'h0);
      check(rd[11:0] === 12'h02b, "errors cleared");
      apb(1'b1, 8'h00, 32'h0);
      #1;
      check(instr_ready === 1'b0, "disabled fetch");
      apb(1'b1, 8'h00, 32'h1);
      $display("test two word done");
      @(posedge core_clk);
      flag_upd <= {5'h1f, 5'h15, 1'b0};
      @(posedge core_clk);
      flag_upd <= {5'h10, 5'h00, 1'b1};
      @(posedge core_clk);
      flag_upd <= {5'h10, 5'h10, 1'b1};
      @(posedge core_clk);
      flag_upd <= '0;
      #1;
      check(status_flags === 5'h05, "sticky zero");
      apb(1'b0, 8'h08, 32'h0);
      check(rd === 32'h5, "flags read");
      apb(1'b0, 8'h0c, 32'h0);
      check(rd === 32'h1b, "decode count");
      $display("test flags done");
      conclude();
   end
endmodule : mcu_instruction_decode_timing_tb

// *** tb/prog_mem.sv ***
`timescale 1ns/1ps
module prog_mem
   import decode_pkg::*;
(
   // clock and reset
   input  wire logic   core_clk,
   input  wire logic   reset_n,
   // fetch handshake
   input  wire logic   instr_ready,
   output logic        instr_valid,
   output logic [23:0] instr_word,
   output exec_cond_t  exec_cond
);
   initial
   begin
      instr_valid = 1'b0;
      instr_word  = 24'h5a5a5a;
      exec_cond   = '0;
   end
   // called just after an edge; held until taken
   task automatic offer(input logic [23:0] w, input exec_cond_t c,
                        input logic last);
      int n;
      n = 0;
      instr_valid <= 1'b1;
      instr_word  <= w;
      exec_cond   <= c;
      @(posedge core_clk);
      while (instr_ready !== 1'b1 && n < 40)
      begin
         n++;
         @(posedge core_clk);
      end
      if (n == 40)
         mcu_instruction_decode_timing_tb.stuck();
      // released lines show inverted junk, never the old word
      if (last)
      begin
         instr_valid <= 1'b0;
         instr_word  <= ~w;
         exec_cond   <= ~c;
      end
   endtask : offer
endmodule : prog_mem
